// file: hdl/sdram_cmd_pkg.sv
// Contract
// - every pin input is sampled on the rising clock edge only
// - each edge advances the burst address and output registers during a burst
// - clock gate sampled low suspends the internal clock from the next cycle
// - while suspended, outputs and burst address stay frozen
// - power down or self refresh entered only with both banks idle
// - in power down or self refresh the clock gate is treated as asynchronous
// - in power down or self refresh all other inputs are ignored
// - activate, read, write and single precharge act on the selected bank
// - activate latches the full 11-bit row for the selected bank
// - read/write take column from low 8 lines; precharge flag requests auto precharge
// - precharge with flag high closes both banks, else the selected one
// - mode load copies the address lines into the mode register
// - each bank holds 2048 rows by 256 columns of 16-bit words
// - bursts start at the addressed column, programmed length and order
// - burst lengths of 1, 2, 4, 8 words or full page
// - a stop command ends a burst early
// - auto precharge closes the row when a fixed-length burst completes, not after a stop or in full page
// - burst order is linear or interleaved per mode register
// - auto refresh on command; self refresh timed internally, 4096 per 64 ms
// - each data byte has its own mask
// - high mask governs bits 15:8, low mask 7:0; read mask lags two clocks
// - chip select high makes every command ignored
// - row strobe low, column strobe high: write strobe high activates, low precharges
package sdram_cmd_pkg;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int NBYTE = 2;
    localparam int MEM_AW = 1 + ROW_W + COL_W;
    localparam int WORD_W = MEM_AW + DATA_W + NBYTE;
    localparam int PRE_FLAG_BIT = 10;

    // mode register layout
    localparam int MODE_W = ROW_W;
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BL_W = 3;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_CL_W = 3;
    localparam logic [MODE_W-1:0] MODE_RESET = 11'h020;
    localparam logic [MODE_BL_W-1:0] BL_1 = 3'h0;
    localparam logic [MODE_BL_W-1:0] BL_2 = 3'h1;
    localparam logic [MODE_BL_W-1:0] BL_4 = 3'h2;
    localparam logic [MODE_BL_W-1:0] BL_8 = 3'h3;
    localparam logic [MODE_CL_W-1:0] CL_1 = 3'h1;
    localparam logic [MODE_CL_W-1:0] CL_2 = 3'h2;
    localparam logic [COL_W-1:0] PAGE_MASK = 8'hff;

    // refresh timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_WINDOW_MS = 64;
    localparam int REF_ROWS = 4096;
    localparam int REF_CYC = (REF_WINDOW_MS * 1000000) / REF_ROWS / CLK_PERIOD_NS;
    localparam int REF_CNT_W = 12;

    typedef enum logic [1:0] {pwr_normal, pwr_down, pwr_self} pwr_t;
    typedef enum logic [2:0] {cmd_nop, cmd_act, cmd_pre, cmd_rd, cmd_wr, cmd_mrs, cmd_stop,
        cmd_aref} cmd_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank;
        logic [ROW_W-1:0] addr;
        logic [NBYTE-1:0] dqm;
        logic [DATA_W-1:0] dq;
    } pins_t;

    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
        default: '0};

    function automatic cmd_t decode_cmd(pins_t p);
        if (p.cs_n) begin
            return cmd_nop;
        end
        case ({p.ras_n, p.cas_n, p.we_n})
            3'h3: return cmd_act;
            3'h2: return cmd_pre;
            3'h5: return cmd_rd;
            3'h4: return cmd_wr;
            3'h0: return cmd_mrs;
            3'h6: return cmd_stop;
            3'h1: return cmd_aref;
            default: return cmd_nop;
        endcase
    endfunction

    // reserved length codes behave as full page
    function automatic logic [COL_W-1:0] burst_mask(logic [MODE_BL_W-1:0] bl);
        case (bl)
            BL_1: return 8'h00;
            BL_2: return 8'h01;
            BL_4: return 8'h03;
            BL_8: return 8'h07;
            default: return PAGE_MASK;
        endcase
    endfunction

    function automatic logic [COL_W-1:0] burst_col(logic [COL_W-1:0] start,
        logic [COL_W-1:0] idx, logic [MODE_BL_W-1:0] bl, logic ilv);
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] low;
        m = burst_mask(bl);
        low = ilv ? (start ^ idx) : COL_W'(start + idx);
        return (start & ~m) | (low & m);
    endfunction
endpackage

// file: hdl/sdram_wr_fifo.sv
module sdram_wr_fifo
    import sdram_cmd_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_t;

    fifo_t q;
    fifo_t n;
    logic wr;
    logic rd;

    assign o_in_ready = q.cnt != FULL;
    assign o_out_valid = q.cnt != '0;
    assign o_out_data = q.mem[q.rp];

    always_comb begin
        n = q;
        wr = i_in_valid && o_in_ready;
        rd = o_out_valid && i_out_ready;
        if (wr) begin
            n.mem[q.wp] = i_in_data;
            n.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
        end
        if (rd) begin
            n.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
        end
        if (wr && !rd) begin
            n.cnt = q.cnt + 1'b1;
        end else if (rd && !wr) begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule

// file: hdl/sdram_cmd_if.sv
module sdram_cmd_if
    import sdram_cmd_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int REF_CYCLES = REF_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // command pins
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_bank_select_line,
    input wire logic [ROW_W-1:0] i_row_col_addr_lines,
    input wire logic i_high_byte_mask,
    input wire logic i_low_byte_mask,
    // data pins
    input wire logic [DATA_W-1:0] i_data_lines,
    output logic [DATA_W-1:0] o_data_lines,
    output logic [NBYTE-1:0] o_data_lines_oe,
    // status
    output logic [1:0] o_bank_open,
    output logic o_power_down,
    output logic o_self_refresh,
    output logic o_refresh_pulse,
    output logic o_wr_ready
);
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic cke1;
        logic cke2;
        logic ck_prev;
        pwr_t pwr;
        logic [MODE_W-1:0] mode;
        logic [1:0] open;
        logic [1:0][ROW_W-1:0] row;
        logic bact;
        logic bwr;
        logic bbank;
        logic bpre;
        logic [COL_W-1:0] bstart;
        logic [COL_W-1:0] bidx;
        logic [1:0] pv;
        logic [1:0][DATA_W-1:0] pd;
        logic [NBYTE-1:0] dqm_d;
        logic [DATA_W-1:0] dq;
        logic [NBYTE-1:0] oe;
        logic ovld;
        logic [REF_CNT_W-1:0] refcnt;
        logic rpulse;
    } state_t;

    localparam state_t STATE_RESET = '{s1: PINS_IDLE, s2: PINS_IDLE, pwr: pwr_normal,
        mode: MODE_RESET, default: '0};
    localparam logic [REF_CNT_W-1:0] REF_LAST = REF_CNT_W'(REF_CYCLES - 1);

    state_t q;
    state_t n;

    // storage is sized to the full array; shrink ROW_W for small simulations
    logic [DATA_W-1:0] mem [2**MEM_AW];

    cmd_t cmd;
    logic run;
    logic frz;
    logic go;
    logic cw;
    logic cb;
    logic cp;
    logic last;
    logic [COL_W-1:0] cs;
    logic [COL_W-1:0] ci;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] m;
    logic [MODE_CL_W-1:0] cl;
    logic [MEM_AW-1:0] addr;
    logic rv;
    logic [DATA_W-1:0] rdat;
    logic kill;
    logic push;
    logic [WORD_W-1:0] push_word;
    logic f_valid;
    logic f_ready;
    logic [WORD_W-1:0] f_word;
    logic mem_we;
    logic [MEM_AW-1:0] f_addr;
    logic [DATA_W-1:0] f_data;
    logic [NBYTE-1:0] f_be;

    assign frz = (q.pwr == pwr_normal) && !q.ck_prev;
    assign run = (q.pwr == pwr_normal) && q.ck_prev;
    assign cl = q.mode[MODE_CL_LSB+:MODE_CL_W];
    assign m = burst_mask(q.mode[MODE_BL_LSB+:MODE_BL_W]);

    always_comb begin
        n = q;
        n.rpulse = 1'b0;
        cmd = run ? decode_cmd(q.s2) : cmd_nop;
        go = 1'b0;
        cw = q.bwr;
        cb = q.bbank;
        cp = q.bpre;
        cs = q.bstart;
        ci = q.bidx;
        col = '0;
        last = 1'b0;
        addr = '0;
        rv = 1'b0;
        rdat = '0;
        push = 1'b0;
        push_word = '0;
        kill = 1'b0;
        // the clock gate keeps its own synchroniser in every mode
        n.cke1 = i_cke;
        n.cke2 = q.cke1;
        n.ck_prev = q.cke2;
        if (q.pwr == pwr_normal) begin
            n.s1 = '{cs_n: i_cs_n, ras_n: i_ras_n, cas_n: i_cas_n, we_n: i_we_n,
                bank: i_bank_select_line, addr: i_row_col_addr_lines,
                dqm: {i_high_byte_mask, i_low_byte_mask}, dq: i_data_lines};
            n.s2 = q.s1;
        end else begin
            // input buffers off; flush so nothing stale runs at wake-up
            n.s1 = PINS_IDLE;
            n.s2 = PINS_IDLE;
        end

        if (run) begin
            n.pv = {q.pv[0], 1'b0};
            n.pd = {q.pd[0], {DATA_W{1'b0}}};
            n.dqm_d = q.s2.dqm;
            kill = (cmd == cmd_stop)
                || (cmd == cmd_pre && (q.s2.addr[PRE_FLAG_BIT] || q.s2.bank == q.bbank));
            if (cmd == cmd_rd || cmd == cmd_wr) begin
                go = 1'b1;
                cw = (cmd == cmd_wr);
                cb = q.s2.bank;
                cs = q.s2.addr[COL_W-1:0];
                cp = q.s2.addr[PRE_FLAG_BIT];
                ci = '0;
            end else if (q.bact && !kill) begin
                go = 1'b1;
            end else if (kill) begin
                n.bact = 1'b0;
            end
            if (go) begin
                col = burst_col(cs, ci, q.mode[MODE_BL_LSB+:MODE_BL_W], q.mode[MODE_BT_BIT]);
                addr = {cb, q.row[cb], col};
                last = (m != PAGE_MASK) && (ci == m);
                n.bact = !last;
                n.bwr = cw;
                n.bbank = cb;
                n.bpre = cp;
                n.bstart = cs;
                n.bidx = ci + 1'b1;
                if (last && cp) begin
                    n.open[cb] = 1'b0;
                end
                if (cw) begin
                    push = 1'b1;
                    push_word = {addr, q.s2.dq, ~q.s2.dqm};
                end else begin
                    n.pv[0] = 1'b1;
                    n.pd[0] = mem[addr];
                end
            end
            case (cl)
                CL_1: begin
                    rv = go && !cw;
                    rdat = n.pd[0];
                end
                CL_2: begin
                    rv = q.pv[0];
                    rdat = q.pd[0];
                end
                default: begin
                    rv = q.pv[1];
                    rdat = q.pd[1];
                end
            endcase
            n.ovld = rv;
            n.dq = rv ? rdat : q.dq;
            n.oe = rv ? ~q.dqm_d : '0;
            case (cmd)
                cmd_act: begin
                    n.open[q.s2.bank] = 1'b1;
                    n.row[q.s2.bank] = q.s2.addr;
                end
                cmd_pre: begin
                    if (q.s2.addr[PRE_FLAG_BIT]) begin
                        n.open = '0;
                    end else begin
                        n.open[q.s2.bank] = 1'b0;
                    end
                end
                cmd_mrs: n.mode = q.s2.addr;
                cmd_aref: n.rpulse = q.cke2;
                default: ;
            endcase
            if (!q.cke2 && q.open == '0 && !q.bact
                && (cmd == cmd_nop || cmd == cmd_aref)) begin
                n.pwr = (cmd == cmd_aref) ? pwr_self : pwr_down;
                n.refcnt = '0;
                n.oe = '0;
                n.ovld = 1'b0;
            end
        end else if (q.pwr != pwr_normal) begin
            if (q.cke2) begin
                n.pwr = pwr_normal;
            end
            if (q.pwr == pwr_self) begin
                n.refcnt = (q.refcnt == REF_LAST) ? '0 : q.refcnt + 1'b1;
                n.rpulse = (q.refcnt == REF_LAST);
            end
        end
        // frozen: burst, pipeline and outputs keep their values
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= STATE_RESET;
        end else begin
            q <= n;
        end
    end

    // writes drain only while the internal clock runs, as pushes do, so the fifo holds at most one word
    assign mem_we = f_valid && f_ready;
    assign f_ready = run;
    assign {f_addr, f_data, f_be} = f_word;

    sdram_wr_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_in_valid(push),
        .o_in_ready(o_wr_ready),
        .i_in_data(push_word),
        .o_out_valid(f_valid),
        .i_out_ready(f_ready),
        .o_out_data(f_word)
    );

    always_ff @(posedge i_ref_clk) begin
        if (mem_we) begin
            for (int b = 0; b < NBYTE; b++) begin
                if (f_be[b]) begin
                    mem[f_addr][b*BYTE_W+:BYTE_W] <= f_data[b*BYTE_W+:BYTE_W];
                end
            end
        end
    end

    assign o_data_lines = q.dq;
    assign o_data_lines_oe = q.oe;
    assign o_bank_open = q.open;
    assign o_power_down = q.pwr == pwr_down;
    assign o_self_refresh = q.pwr == pwr_self;
    assign o_refresh_pulse = q.rpulse;

    default clocking dcb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_act;
        cmd == cmd_act;
    endsequence
    sequence s_pre_all;
        cmd == cmd_pre && q.s2.addr[PRE_FLAG_BIT];
    endsequence
    sequence s_rd_cl2;
        cmd == cmd_rd && cl == CL_2;
    endsequence
    sequence s_enter_low;
        q.pwr == pwr_normal ##1 q.pwr != pwr_normal;
    endsequence
    sequence s_col_cmd;
        cmd == cmd_rd || cmd == cmd_wr;
    endsequence

    AST_DESELECT_IGNORED: assert property (
        (run && q.s2.cs_n && !q.bact) |=> ($stable(q.open) && $stable(q.mode)))
        else $error("deselected command changed state");
    AST_SUSPEND_START: assert property (
        (run && !q.cke2 && q.bact) |=> frz)
        else $error("clock not suspended after gate low");
    AST_SUSPEND_HOLD: assert property (
        frz |=> ($stable(q.dq) && $stable(q.oe) && $stable(q.bidx)))
        else $error("state moved while suspended");
    AST_ACT_ROW: assert property (
        s_act |=> (q.open[$past(q.s2.bank)] && q.row[$past(q.s2.bank)] == $past(q.s2.addr)))
        else $error("activate did not open the row");
    AST_PRE_ALL: assert property (
        s_pre_all |=> q.open == 2'h0)
        else $error("precharge all left a bank open");
    AST_BURST_STEP: assert property (
        (run && q.bact && cmd == cmd_nop) |=> q.bidx == COL_W'($past(q.bidx) + 1'b1))
        else $error("burst address did not advance");
    AST_READ_LAT2: assert property (
        s_rd_cl2 ##1 run |=> q.ovld)
        else $error("read data late for latency two");
    AST_LOWPWR_IDLE: assert property (
        s_enter_low |-> (q.open == 2'h0 && !q.bact))
        else $error("low power entered with a bank open");
    AST_AUTOPRE: assert property (
        (go && last && cp && cmd != cmd_act) |=> !q.open[$past(cb)])
        else $error("auto precharge did not close the bank");
    AST_PDOWN_INPUTS: assert property (
        (q.pwr != pwr_normal)[*2] |-> q.s2.cs_n)
        else $error("inputs sampled during low power");
    AST_WAKE: assert property (
        (q.pwr != pwr_normal && q.cke2) |=> q.pwr == pwr_normal)
        else $error("no exit from low power");
    AST_BANK_TAKE: assert property (
        s_col_cmd |=> q.bbank == $past(q.s2.bank))
        else $error("column command went to the wrong bank");
    AST_COL_TAKE: assert property (
        s_col_cmd |=> (q.bstart == $past(q.s2.addr[COL_W-1:0])
            && q.bpre == $past(q.s2.addr[PRE_FLAG_BIT])))
        else $error("column or auto precharge flag not taken");
    AST_PRE_ONE: assert property (
        (cmd == cmd_pre && !q.s2.addr[PRE_FLAG_BIT]) |=> !q.open[$past(q.s2.bank)])
        else $error("single precharge left the bank open");
    AST_MODE_LOAD: assert property (
        (cmd == cmd_mrs) |=> q.mode == $past(q.s2.addr))
        else $error("mode register not loaded");
    AST_STOP_END: assert property (
        (cmd == cmd_stop) |=> !q.bact)
        else $error("burst kept running after stop");
    AST_READ_LAT1: assert property (
        (cmd == cmd_rd && cl == CL_1) |=> q.ovld)
        else $error("read data late for latency one");
    AST_REF_PULSE: assert property (
        (cmd == cmd_aref && q.cke2) |=> q.rpulse)
        else $error("auto refresh gave no pulse");
    AST_READ_MASK: assert property (
        (rv && q.cke2 && $past(run)) |=> q.oe == ~$past(q.s2.dqm, 2))
        else $error("read mask not applied two clocks later");
endmodule

// file: test/sdram_ctrl_model.sv
module sdram_ctrl_model
    import sdram_cmd_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // requests from the bench
    input wire cmd_t i_op,
    input wire logic i_desel,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wvalid,
    // pins toward the device
    output logic o_cs_n,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic [DATA_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] last_ff = 16'h0000;
    always @(posedge i_ref_clk) begin
        if (i_wvalid) begin
            last_ff <= i_wdata;
        end
    end
    // released lines show the inverse, so a stale word can never pass as fresh
    assign o_data = i_wvalid ? i_wdata : ~last_ff;
    always_comb begin
        o_cs_n = i_desel;
        case (i_op)
            cmd_act: {o_ras_n, o_cas_n, o_we_n} = 3'h3;
            cmd_pre: {o_ras_n, o_cas_n, o_we_n} = 3'h2;
            cmd_rd: {o_ras_n, o_cas_n, o_we_n} = 3'h5;
            cmd_wr: {o_ras_n, o_cas_n, o_we_n} = 3'h4;
            cmd_mrs: {o_ras_n, o_cas_n, o_we_n} = 3'h0;
            cmd_stop: {o_ras_n, o_cas_n, o_we_n} = 3'h6;
            cmd_aref: {o_ras_n, o_cas_n, o_we_n} = 3'h1;
            default: {o_ras_n, o_cas_n, o_we_n} = 3'h7;
        endcase
    end
endmodule

// file: test/sdram_two_bank_cmd_interface_tb_top.sv
module sdram_two_bank_cmd_interface_tb_top
    import sdram_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [31:0] at; logic [1:0] oe; logic [15:0] d;} beat_t;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    cmd_t op_r = cmd_nop;
    logic desel_r = 1'b0;
    logic cke_r = 1'b1;
    logic bank_r = 1'b0;
    logic wv_r = 1'b0;
    logic [10:0] addr_r = 11'h000;
    logic [1:0] dqm_r = 2'h0;
    logic [15:0] wd_r = 16'h0000;
    logic cs_n, ras_n, cas_n, we_n, pd, sr, refp, wrdy;
    logic [15:0] dq_in, dq_out;
    logic [1:0] oe, bopen;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int refs = 0;
    logic [31:0] seed = 32'd11;
    beat_t exp_q[$];
    beat_t hd;
    logic [15:0] mem[int];
    logic [10:0] row_of[2];
    logic [2:0] bls[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic ilvs[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [2:0] cls[5] = '{3'h1, 3'h2, 3'h3, 3'h2, 3'h2};

    sdram_ctrl_model ctrl (.i_ref_clk(i_ref_clk), .i_op(op_r), .i_desel(desel_r),
        .i_wdata(wd_r), .i_wvalid(wv_r), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
        .o_we_n(we_n), .o_data(dq_in));
    sdram_cmd_if #(.FIFO_DEPTH(8), .REF_CYCLES(8)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_cke(cke_r), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
        .i_bank_select_line(bank_r), .i_row_col_addr_lines(addr_r),
        .i_high_byte_mask(dqm_r[1]), .i_low_byte_mask(dqm_r[0]), .i_data_lines(dq_in),
        .o_data_lines(dq_out), .o_data_lines_oe(oe), .o_bank_open(bopen), .o_power_down(pd),
        .o_self_refresh(sr), .o_refresh_pulse(refp), .o_wr_ready(wrdy));

    always #5 i_ref_clk = ~i_ref_clk;

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] col_at(logic [7:0] s, logic [7:0] i, logic [2:0] bl,
        logic ilv);
        logic [7:0] m;
        logic [7:0] lo;
        m = (bl < 3'h4) ? 8'((1 << bl) - 1) : 8'hff;
        lo = ilv ? (s ^ i) : 8'(s + i);
        return (s & ~m) | (lo & m);
    endfunction
    function int key(logic b, logic [7:0] c);
        return int'({b, row_of[b], c});
    endfunction
    function logic [15:0] peek(int k);
        return mem.exists(k) ? mem[k] : 16'hxxxx;
    endfunction
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task give_verdict();
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task step(cmd_t op, logic b, logic [10:0] a, logic [15:0] d, logic v);
        @(posedge i_ref_clk);
        op_r <= op;
        bank_r <= b;
        addr_r <= a;
        wd_r <= d;
        wv_r <= v;
    endtask
    task idle(int n);
        repeat (n) step(cmd_nop, 1'b0, 11'(xs()), 16'h0000, 1'b0);
    endtask
    task act(logic b, logic [10:0] r);
        row_of[b] = r;
        step(cmd_act, b, r, 16'h0000, 1'b0);
        idle(4);
    endtask
    task wr(logic b, logic [7:0] c, int n, logic [2:0] bl, logic ilv, logic stp);
        logic [15:0] d;
        logic [15:0] o;
        int k;
        for (int i = 0; i < n; i++) begin
            d = 16'(xs());
            step((i == 0) ? cmd_wr : cmd_nop, b, {3'h0, c}, d, 1'b1);
            k = key(b, col_at(c, 8'(i), bl, ilv));
            o = peek(k);
            mem[k] = {dqm_r[1] ? o[15:8] : d[15:8], dqm_r[0] ? o[7:0] : d[7:0]};
        end
        if (stp) begin
            step(cmd_stop, 1'b0, 11'h000, 16'h0000, 1'b0);
        end
        idle(6);
    endtask
    // full page reads end on a stop placed right after the last wanted beat
    task rd(logic b, logic [7:0] c, int n, logic [2:0] bl, logic ilv, logic [2:0] cl,
        logic stp, logic ap);
        int k;
        step(cmd_rd, b, {ap, 2'h0, c}, 16'h0000, 1'b0);
        k = cyc;
        for (int i = 0; i < n; i++) begin
            exp_q.push_back('{k + 3 + cl + i, ~dqm_r, peek(key(b, col_at(c, 8'(i), bl, ilv)))});
        end
        idle(n - 1);
        if (stp) begin
            step(cmd_stop, 1'b0, 11'h000, 16'h0000, 1'b0);
        end
        idle(cl + 6);
    endtask
    // eight write beats with one suspended cycle, all through the write fifo
    task fifo_test();
        logic [15:0] d;
        int j;
        step(cmd_mrs, 1'b0, 11'h023, 16'h0000, 1'b0);
        idle(4);
        act(1'b0, 11'(xs()));
        chk("fifo bank", 1, bopen);
        j = 0;
        for (int i = 0; i < 9; i++) begin
            d = 16'(xs());
            step((i == 0) ? cmd_wr : cmd_nop, 1'b0, 11'h000, d, 1'b1);
            cke_r <= (i != 1);
            chk("wr ready", 1, wrdy);
            // the pin cycle after the gate drops is not taken
            if (i != 2) begin
                mem[key(1'b0, 8'(j))] = d;
                j++;
            end
        end
        idle(6);
        rd(1'b0, 8'h00, 8, 3'h3, 1'b0, 3'h2, 1'b0, 1'b0);
        chk("fifo drained", 0, exp_q.size());
        step(cmd_pre, 1'b0, 11'h400, 16'h0000, 1'b0);
        idle(4);
        chk("fifo closed", 0, bopen);
    endtask

    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (!i_rst) begin
            if (refp === 1'b1) begin
                refs <= refs + 1;
            end
            if (oe !== 2'b00) begin
                if (exp_q.size() == 0) begin
                    chk("extra beat", 0, 1);
                end else begin
                    hd = exp_q.pop_front();
                    chk("beat time", hd.at, cyc);
                    chk("beat oe", hd.oe, oe);
                    chk("beat data", hd.d & {{8{hd.oe[1]}}, {8{hd.oe[0]}}},
                        dq_out & {{8{hd.oe[1]}}, {8{hd.oe[0]}}});
                end
            end
        end
    end

    initial begin
        #100us;
        err_total++;
        give_verdict();
    end

    initial begin
        logic b;
        logic [7:0] c;
        logic [7:0] c0;
        logic [10:0] r0;
        int n;
        int n0;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        idle(6);
        chk("reset state", 0, {oe, bopen, pd, sr});
        chk("reset wr_ready", 1, wrdy);
        fifo_test();
        for (int i = 0; i < 5; i++) begin
            b = i[0];
            c = (bls[i] > 3'h3) ? 8'hfe : 8'(xs());
            n = (bls[i] > 3'h3) ? 4 : (1 << bls[i]);
            step(cmd_mrs, 1'b0, {4'h0, cls[i], ilvs[i], bls[i]}, 16'h0000, 1'b0);
            idle(4);
            act(b, 11'(xs()));
            chk("bank open", 1 << b, bopen);
            if (i == 0) begin
                c0 = c;
                r0 = row_of[0];
            end
            wr(b, c, n, bls[i], ilvs[i], bls[i] > 3'h3);
            rd(b, c, n, bls[i], ilvs[i], cls[i], bls[i] > 3'h3, 1'b0);
            step(cmd_pre, b, 11'h000, 16'h0000, 1'b0);
            idle(4);
            chk("bank closed", 0, bopen);
        end
        step(cmd_mrs, 1'b0, 11'h010, 16'h0000, 1'b0);
        idle(4);
        act(1'b0, r0);
        rd(1'b0, c0, 1, 3'h0, 1'b0, 3'h1, 1'b0, 1'b0);
        dqm_r <= 2'b10;
        wr(1'b0, c0, 1, 3'h0, 1'b0, 1'b0);
        dqm_r <= 2'b00;
        rd(1'b0, c0, 1, 3'h0, 1'b0, 3'h1, 1'b0, 1'b0);
        dqm_r <= 2'b01;
        rd(1'b0, c0, 1, 3'h0, 1'b0, 3'h1, 1'b0, 1'b1);
        dqm_r <= 2'b00;
        chk("auto precharge", 0, bopen);
        act(1'b0, 11'(xs()));
        act(1'b1, 11'(xs()));
        chk("both open", 3, bopen);
        step(cmd_pre, 1'b1, 11'h000, 16'h0000, 1'b0);
        idle(4);
        chk("single close", 1, bopen);
        act(1'b1, 11'(xs()));
        step(cmd_pre, 1'b0, 11'h400, 16'h0000, 1'b0);
        idle(4);
        chk("close all", 0, bopen);
        desel_r <= 1'b1;
        act(1'b0, 11'(xs()));
        desel_r <= 1'b0;
        chk("deselected", 0, bopen);
        n0 = refs;
        step(cmd_aref, 1'b0, 11'h000, 16'h0000, 1'b0);
        idle(5);
        chk("auto refresh", n0 + 1, refs);
        step(cmd_aref, 1'b0, 11'h000, 16'h0000, 1'b0);
        cke_r <= 1'b0;
        idle(4);
        chk("self refresh", 1, sr);
        n0 = refs;
        idle(40);
        chk("self ticks", 1, (refs - n0) inside {[4:6]});
        cke_r <= 1'b1;
        idle(6);
        chk("self exit", 0, sr);
        cke_r <= 1'b0;
        idle(4);
        chk("power down", 1, pd);
        act(1'b1, 11'(xs()));
        cke_r <= 1'b1;
        idle(6);
        chk("power exit", 0, {pd, bopen});
        chk("all beats seen", 0, exp_q.size());
        give_verdict();
    end
endmodule
